// ===== bench/sfr_cpu_model.sv
`timescale 1ns/100ps
module sfr_cpu_model
  import sfr_space_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic i_refused,
  input wire logic [15:0] i_rdata,
  output logic o_req,
  output logic o_write,
  output logic [15:0] o_addr,
  output logic [1:0] o_width,
  output logic [2:0] o_bit_pos,
  output logic [15:0] o_wdata
);
  initial
    {o_req, o_write, o_addr, o_width, o_bit_pos, o_wdata} = '0;
  task automatic access(input logic w, input logic [15:0] a,
    input logic [1:0] wd, input logic [2:0] bp, input logic [15:0] d,
    input logic odd, output logic ack, output logic refd,
    output logic [15:0] rd);
    @(posedge i_clock);
    #1;
    o_req = 1'b1;
    o_write = w;
    // a misaligned word goes out only when a test asks for it
    o_addr = (wd == WIDTH_WORD && !odd) ? {a[15:1], 1'b0} : a;
    o_width = wd;
    o_bit_pos = bp;
    o_wdata = d;
    @(posedge i_clock);
    #1;
    // the answer stands only in the cycle after the taking edge
    ack = i_ack;
    refd = i_refused;
    rd = i_rdata;
    // released lines change so a stale value can never look valid
    o_req = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~d;
  endtask
endmodule

// ===== bench/sfr_space_decode_bank_sva.sv
`timescale 1ns/100ps
module sfr_space_check
  import sfr_space_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic I_REQ,
  input wire logic I_WRITE,
  input wire logic [15:0] I_ADDR,
  input wire logic [1:0] I_WIDTH,
  input wire logic O_ACK,
  input wire logic O_REFUSED,
  input wire logic [15:0] O_RDATA
);
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);
  wire logic hit = I_REQ && I_ADDR[15:8] == WINDOW_PAGE;
  wire logic rd = hit && !I_WRITE;
  a_window_ack: assert property (hit |=> O_ACK) else $error("no answer");
  a_outside_quiet: assert property (!hit |=> !O_ACK)
    else $error("answer without access");
  a_refuse_ack: assert property (O_REFUSED |-> O_ACK)
    else $error("refusal without answer");
  a_odd_word: assert property (hit && I_ADDR[0]
    && I_WIDTH == WIDTH_WORD |=> O_REFUSED) else $error("odd word taken");
  a_wo_read: assert property (rd && I_ADDR == OFS_TIMER_A_COMPARE
    |=> O_REFUSED && O_RDATA == 16'h0000) else $error("compare read");
  a_ro_write: assert property (hit && I_WRITE
    && I_ADDR == OFS_TIMER_A_COUNT |=> O_REFUSED) else $error("count written");
  a_byte_only: assert property (hit && I_WIDTH == WIDTH_BIT
    && I_ADDR == OFS_WATCHDOG_CLOCK_SELECT |=> O_REFUSED)
    else $error("bit access taken");
  a_word_product: assert property (rd && I_WIDTH == WIDTH_WORD
    && I_ADDR == OFS_PRODUCT_LOW |=> !O_REFUSED) else $error("word refused");
  a_rdata_hold: assert property (!rd |=> $stable(O_RDATA))
    else $error("read data moved");
endmodule
bind sfr_space_decode_bank sfr_space_check chk_u (.I_CLOCK(I_CLOCK),
  .I_NRST(I_NRST), .I_REQ(I_REQ), .I_WRITE(I_WRITE), .I_ADDR(I_ADDR),
  .I_WIDTH(I_WIDTH), .O_ACK(O_ACK), .O_REFUSED(O_REFUSED),
  .O_RDATA(O_RDATA));

// ===== bench/sfr_space_decode_bank_test.sv
`timescale 1ns/100ps
module sfr_space_decode_bank_test;
  import sfr_space_pkg::*;
  localparam logic [2:0] ok = 3'b010, no = 3'b011, odd = 3'b111;
  localparam logic [15:0] ro_map [11] = '{OFS_PORT6_INPUT, OFS_PORT8_INPUT,
    OFS_CONVERTER_RESULT, OFS_PRODUCT_LOW, OFS_PRODUCT_HIGH,
    OFS_REMOTE_CAPTURE_A, OFS_REMOTE_CAPTURE_B, OFS_TIMER_A_COUNT,
    OFS_TIMER_B_COUNT, OFS_TIMER_C_COUNT, OFS_TIMER_D_COUNT};
  localparam logic [15:0] wr_map [17] = '{OFS_PORT1_DATA, OFS_PORT2_DATA,
    OFS_PORT3_DATA, OFS_PORT_DIRECTION_1, OFS_PORT_DIRECTION_2,
    OFS_PORT_DIRECTION_3, OFS_WATCH_TIMER_CONTROL, OFS_WATCHDOG_MODE,
    OFS_PORT3_FUNCTION, OFS_REMOTE_TIMER_CONTROL, OFS_TIMER_B_COMPARE,
    OFS_TIMER_B_MODE, OFS_TIMER_C_COMPARE, OFS_TIMER_C_MODE,
    OFS_TIMER_D_COMPARE, OFS_TIMER_D_MODE, OFS_TIMER_E_COMPARE};
  logic clk, nrst, req, wr, ack, refd;
  logic [15:0] addr, wdata, rdata, rd;
  logic [1:0] width;
  logic [2:0] bpos;
  logic [7:0] pv [11];
  logic [7:0] wv [17];
  logic gw, gp;
  logic [2:0] gs;
  logic [15:0] gd, ggr;
  logic [7:0] p0, dir0, pu2, pu3, wdc, tam, cra, crh;
  int err_count = 0;
  int checks = 0;
  sfr_space_decode_bank dut_u (.I_CLOCK(clk), .I_NRST(nrst), .I_REQ(req),
    .I_WRITE(wr), .I_ADDR(addr), .I_WIDTH(width), .I_BIT_POS(bpos),
    .I_WDATA(wdata), .I_PORT6_PINS(pv[0]), .I_PORT8_PINS(pv[1]),
    .I_CONVERTER_RESULT(pv[2]), .I_PRODUCT_WORD({pv[4], pv[3]}),
    .I_REMOTE_CAPTURE_A(pv[5]), .I_REMOTE_CAPTURE_B(pv[6]),
    .I_TIMER_A_COUNT(pv[7]), .I_TIMER_B_COUNT(pv[8]),
    .I_TIMER_C_COUNT(pv[9]), .I_TIMER_D_COUNT(pv[10]),
    .I_GPR_WRITE(gw), .I_GPR_PAIR(gp), .I_GPR_SEL(gs), .I_GPR_WDATA(gd),
    .O_ACK(ack), .O_REFUSED(refd), .O_RDATA(rdata), .O_GPR_RDATA(ggr),
    .O_PORT0_DATA(p0), .O_PORT1_DATA(wv[0]), .O_PORT2_DATA(wv[1]),
    .O_PORT3_DATA(wv[2]), .O_PORT_DIRECTION_0(dir0),
    .O_PORT_DIRECTION_1(wv[3]), .O_PORT_DIRECTION_2(wv[4]),
    .O_PORT_DIRECTION_3(wv[5]), .O_PULLUP_OPTION_B2(pu2),
    .O_PULLUP_OPTION_B3(pu3), .O_WATCHDOG_CLOCK_SELECT(wdc),
    .O_WATCH_TIMER_CONTROL(wv[6]), .O_WATCHDOG_MODE(wv[7]),
    .O_PORT3_FUNCTION(wv[8]), .O_REMOTE_TIMER_CONTROL(wv[9]),
    .O_TIMER_A_COMPARE(cra), .O_TIMER_A_MODE(tam),
    .O_TIMER_B_COMPARE(wv[10]), .O_TIMER_B_MODE(wv[11]),
    .O_TIMER_C_COMPARE(wv[12]), .O_TIMER_C_MODE(wv[13]),
    .O_TIMER_D_COMPARE(wv[14]), .O_TIMER_D_MODE(wv[15]),
    .O_TIMER_E_COMPARE(wv[16]), .O_TIMER_E_HIGH_COMPARE(crh));
  sfr_cpu_model cpu_u (.i_clock(clk), .i_ack(ack), .i_refused(refd),
    .i_rdata(rdata), .o_req(req), .o_write(wr), .o_addr(addr),
    .o_width(width), .o_bit_pos(bpos), .o_wdata(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [1:0] wd, input logic [2:0] bp, input logic [15:0] d,
    input logic [2:0] ar);
    logic k, r;
    cpu_u.access(w, a, wd, bp, d, ar[2], k, r, rd);
    chk({14'h0000, k, r}, {14'h0000, ar[1:0]});
  endtask
  task automatic t_rw;
    chk({p0, dir0}, 16'h00ff);
    chk({pu3, pu2}, 16'h0000);
    acc(1'b1, OFS_PORT0_DATA, WIDTH_BYTE, 3'h0, 16'h005a, ok);
    acc(1'b0, OFS_PORT0_DATA, WIDTH_BIT, 3'h1, 16'h0000, ok);
    chk(rd, 16'h0001);
    acc(1'b1, OFS_PORT_DIRECTION_0, WIDTH_BIT, 3'h3, 16'h0000, ok);
    acc(1'b1, OFS_PULLUP_OPTION_B3, WIDTH_BIT, 3'h7, 16'h0001, ok);
    acc(1'b1, OFS_TIMER_A_MODE, WIDTH_BIT, 3'h6, 16'h0001, ok);
    acc(1'b1, OFS_WATCHDOG_CLOCK_SELECT, WIDTH_BYTE, 3'h0,
      16'h0007, ok);
    acc(1'b1, OFS_TIMER_A_COMPARE, WIDTH_BYTE, 3'h0, 16'h0011, ok);
    acc(1'b1, OFS_TIMER_E_HIGH_COMPARE, WIDTH_BYTE, 3'h0,
      16'h0033, ok);
    chk({p0, dir0}, 16'h5af7);
    chk({pu3, tam}, 16'h8040);
    chk({wdc, cra}, 16'h0711);
    chk({8'h00, crh}, 16'h0033);
  endtask
  task automatic t_refuse;
    acc(1'b1, OFS_PORT0_DATA, WIDTH_WORD, 3'h0, 16'hffff, no);
    acc(1'b1, OFS_PORT0_DATA, 2'h3, 3'h0, 16'hffff, no);
    acc(1'b1, 16'hff10, WIDTH_BYTE, 3'h0, 16'hffff, no);
    acc(1'b1, 16'hfe00, WIDTH_BYTE, 3'h0, 16'hffff, 3'b000);
    acc(1'b1, OFS_TIMER_A_COUNT, WIDTH_BYTE, 3'h0, 16'hffff, no);
    acc(1'b1, OFS_WATCHDOG_CLOCK_SELECT, WIDTH_BIT, 3'h0,
      16'h0000, no);
    acc(1'b0, OFS_PRODUCT_HIGH, WIDTH_WORD, 3'h0, 16'h0000, odd);
    acc(1'b0, OFS_CONVERTER_RESULT, WIDTH_BIT, 3'h0, 16'h0000, no);
    acc(1'b0, OFS_TIMER_A_COMPARE, WIDTH_BYTE, 3'h0, 16'h0000, no);
    chk(rd, 16'h0000);
    chk({p0, wdc}, 16'h5a07);
  endtask
  task automatic t_ro;
    for (int i = 0; i < 11; i++)
    begin
      acc(1'b0, ro_map[i], WIDTH_BYTE, 3'h0, 16'h0000, ok);
      chk(rd, {8'h00, pv[i]});
    end
    acc(1'b0, OFS_PRODUCT_LOW, WIDTH_WORD, 3'h0, 16'h0000, ok);
    chk(rd, {pv[4], pv[3]});
  endtask
  task automatic t_gpr;
    @(posedge clk);
    #1;
    {gw, gp, gs, gd} = {1'b1, 1'b1, 3'h0, 16'h1234};
    @(posedge clk);
    #1;
    {gw, gp, gs, gd} = {1'b1, 1'b0, 3'h5, 16'h00ab};
    @(posedge clk);
    #1;
    {gw, gp, gs} = {1'b0, 1'b1, 3'h2};
    @(posedge clk);
    #1;
    chk(ggr, 16'hab00);
    gs = 3'h0;
    @(posedge clk);
    #1;
    chk(ggr, 16'h1234);
    {gp, gs} = {1'b0, 3'h1};
    @(posedge clk);
    #1;
    chk(ggr, 16'h0012);
  endtask
  task automatic t_wr;
    logic [7:0] v;
    for (int i = 0; i < 17; i++)
    begin
      v = (i >= 3 && i <= 5) ? RST_DIRECTION : RST_UNDEFINED;
      chk({8'h00, wv[i]}, {8'h00, v});
      v = 8'h40 + 8'(i);
      acc(1'b1, wr_map[i], WIDTH_BYTE, 3'h0, {8'h00, v}, ok);
      chk({8'h00, wv[i]}, {8'h00, v});
    end
    nrst = 1'b0;
    @(posedge clk);
    #1;
    nrst = 1'b1;
    chk({p0, dir0}, {RST_PORT0_DATA, RST_DIRECTION});
    chk({wv[5], wv[0]}, {RST_DIRECTION, RST_UNDEFINED});
    acc(1'b0, OFS_PORT0_DATA, WIDTH_BYTE, 3'h0, 16'h0000, ok);
    chk(rd, {8'h00, RST_PORT0_DATA});
  endtask
  task automatic final_report;
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    nrst = 1'b0;
    {gw, gp, gs, gd} = '0;
    for (int i = 0; i < 11; i++)
      pv[i] = 8'h31 + 8'(i);
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_rw;
    t_refuse;
    t_ro;
    t_gpr;
    t_wr;
    final_report;
  end
endmodule

// ===== design/sfr_space_decode_bank.sv
`timescale 1ns/100ps
// Contract
// - decode FF00H to FFFFH as the special function register window.
// - accept only each register's permitted widths among bit, byte, word.
// - registers are read/write, read-only or write-only; others refused.
// - reset puts every register to its fixed or undefined start value.
// - port 0 data at FF00H, bit or byte, read/write, resets 00H.
// - four direction registers FF20H-FF23H, bit or byte, reset FFH.
// - converter result FF11H is read-only, byte only, undefined reset.
// - product read-only at FF14H/FF15H, bytewise or one word.
// - timer compare registers are write-only, byte only, undefined.
// - timer count registers are read-only, byte only, reset 00H.
// - timer mode registers are read/write with bit and byte access.
// - remote capture registers FF55H and FF56H read-only, byte only.
// - pull-up registers FF32H and FF33H, bit or byte, reset 00H.
// - watchdog clock select FF42H is read/write, byte access only.
// - compare FF63H and high compare FF64H write-only, byte only.
// - eight working byte registers, also paired into four words.
module sfr_space_decode_bank
  import sfr_space_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  input wire logic I_REQ,
  input wire logic I_WRITE,
  input wire logic [15:0] I_ADDR,
  input wire logic [1:0] I_WIDTH,
  input wire logic [2:0] I_BIT_POS,
  input wire logic [15:0] I_WDATA,
  input wire logic [7:0] I_PORT6_PINS,
  input wire logic [7:0] I_PORT8_PINS,
  input wire logic [7:0] I_CONVERTER_RESULT,
  input wire logic [15:0] I_PRODUCT_WORD,
  input wire logic [7:0] I_REMOTE_CAPTURE_A,
  input wire logic [7:0] I_REMOTE_CAPTURE_B,
  input wire logic [7:0] I_TIMER_A_COUNT,
  input wire logic [7:0] I_TIMER_B_COUNT,
  input wire logic [7:0] I_TIMER_C_COUNT,
  input wire logic [7:0] I_TIMER_D_COUNT,
  input wire logic I_GPR_WRITE,
  input wire logic I_GPR_PAIR,
  input wire logic [2:0] I_GPR_SEL,
  input wire logic [15:0] I_GPR_WDATA,
  output logic O_ACK,
  output logic O_REFUSED,
  output logic [15:0] O_RDATA,
  output logic [15:0] O_GPR_RDATA,
  output logic [7:0] O_PORT0_DATA,
  output logic [7:0] O_PORT1_DATA,
  output logic [7:0] O_PORT2_DATA,
  output logic [7:0] O_PORT3_DATA,
  output logic [7:0] O_PORT_DIRECTION_0,
  output logic [7:0] O_PORT_DIRECTION_1,
  output logic [7:0] O_PORT_DIRECTION_2,
  output logic [7:0] O_PORT_DIRECTION_3,
  output logic [7:0] O_PULLUP_OPTION_B2,
  output logic [7:0] O_PULLUP_OPTION_B3,
  output logic [7:0] O_WATCHDOG_CLOCK_SELECT,
  output logic [7:0] O_WATCH_TIMER_CONTROL,
  output logic [7:0] O_WATCHDOG_MODE,
  output logic [7:0] O_PORT3_FUNCTION,
  output logic [7:0] O_REMOTE_TIMER_CONTROL,
  output logic [7:0] O_TIMER_A_COMPARE,
  output logic [7:0] O_TIMER_A_MODE,
  output logic [7:0] O_TIMER_B_COMPARE,
  output logic [7:0] O_TIMER_B_MODE,
  output logic [7:0] O_TIMER_C_COMPARE,
  output logic [7:0] O_TIMER_C_MODE,
  output logic [7:0] O_TIMER_D_COMPARE,
  output logic [7:0] O_TIMER_D_MODE,
  output logic [7:0] O_TIMER_E_COMPARE,
  output logic [7:0] O_TIMER_E_HIGH_COMPARE
);

  typedef enum logic [1:0] {KIND_NONE, KIND_RW, KIND_RO, KIND_WO} kind_e;

  typedef struct packed {
    kind_e kind;
    logic [2:0] units;
    logic [4:0] slot;
  } attr_s;

  typedef struct packed {
    logic [NUM_RW-1:0][7:0] rw;
    logic [NUM_RO-1:0][7:0] ro;
    logic [7:0] port6_meta;
    logic [7:0] port8_meta;
    logic [15:0] rdata;
    logic [15:0] gpr_rdata;
    logic ack;
    logic refused;
  } state_s;

  state_s state_reg;
  state_s state_next;
  attr_s attr;
  logic in_window;
  logic width_ok;
  logic align_ok;
  logic dir_ok;
  logic access_ok;
  logic [7:0] src_byte;
  logic [7:0] gpr_byte;
  logic [15:0] gpr_pair;

  function automatic attr_s mk(input kind_e kind, input logic [2:0] units,
                               input logic [4:0] slot);
    attr_s a;
    a.kind = kind;
    a.units = units;
    a.slot = slot;
    return a;
  endfunction

  // per-address class, permitted widths and storage slot
  function automatic attr_s decode(input logic [15:0] addr);
    attr_s a;
    a = mk(KIND_NONE, 3'h0, 5'h00);
    case (addr)
      OFS_PORT0_DATA: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PORT0_DATA);
      OFS_PORT1_DATA: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PORT1_DATA);
      OFS_PORT2_DATA: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PORT2_DATA);
      OFS_PORT3_DATA: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PORT3_DATA);
      OFS_PORT6_INPUT: a = mk(KIND_RO, UNITS_BIT_BYTE, SLOT_PORT6);
      OFS_PORT8_INPUT: a = mk(KIND_RO, UNITS_BIT_BYTE, SLOT_PORT8);
      OFS_CONVERTER_RESULT: a = mk(KIND_RO, UNITS_BYTE, SLOT_CONVERTER);
      OFS_PRODUCT_LOW:
        a = mk(KIND_RO, UNITS_BYTE_WORD, SLOT_PRODUCT_LOW);
      OFS_PRODUCT_HIGH: a = mk(KIND_RO, UNITS_BYTE, SLOT_PRODUCT_HIGH);
      OFS_PORT_DIRECTION_0:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_DIRECTION_0);
      OFS_PORT_DIRECTION_1:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_DIRECTION_0 + 5'h01);
      OFS_PORT_DIRECTION_2:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_DIRECTION_0 + 5'h02);
      OFS_PORT_DIRECTION_3:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_DIRECTION_3);
      OFS_PULLUP_OPTION_B2:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PULLUP_B2);
      OFS_PULLUP_OPTION_B3:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PULLUP_B3);
      OFS_WATCHDOG_CLOCK_SELECT:
        a = mk(KIND_RW, UNITS_BYTE, SLOT_WDOG_CLOCK);
      OFS_WATCH_TIMER_CONTROL:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_WATCH_CTRL);
      OFS_WATCHDOG_MODE: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_WDOG_MODE);
      OFS_PORT3_FUNCTION: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_PORT3_FUNC);
      OFS_REMOTE_TIMER_CONTROL:
        a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_REMOTE_CTRL);
      OFS_REMOTE_CAPTURE_A: a = mk(KIND_RO, UNITS_BYTE, SLOT_CAPTURE_A);
      OFS_REMOTE_CAPTURE_B: a = mk(KIND_RO, UNITS_BYTE, SLOT_CAPTURE_B);
      OFS_TIMER_A_COMPARE: a = mk(KIND_WO, UNITS_BYTE, SLOT_A_COMPARE);
      OFS_TIMER_A_COUNT: a = mk(KIND_RO, UNITS_BYTE, SLOT_A_COUNT);
      OFS_TIMER_A_MODE: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_A_MODE);
      OFS_TIMER_B_COMPARE: a = mk(KIND_WO, UNITS_BYTE, SLOT_B_COMPARE);
      OFS_TIMER_B_COUNT: a = mk(KIND_RO, UNITS_BYTE, SLOT_B_COUNT);
      OFS_TIMER_B_MODE: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_B_MODE);
      OFS_TIMER_C_COMPARE: a = mk(KIND_WO, UNITS_BYTE, SLOT_C_COMPARE);
      OFS_TIMER_C_COUNT: a = mk(KIND_RO, UNITS_BYTE, SLOT_C_COUNT);
      OFS_TIMER_C_MODE: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_C_MODE);
      OFS_TIMER_D_COMPARE: a = mk(KIND_WO, UNITS_BYTE, SLOT_D_COMPARE);
      OFS_TIMER_D_COUNT: a = mk(KIND_RO, UNITS_BYTE, SLOT_D_COUNT);
      OFS_TIMER_D_MODE: a = mk(KIND_RW, UNITS_BIT_BYTE, SLOT_D_MODE);
      OFS_TIMER_E_COMPARE:
        a = mk(KIND_WO, UNITS_BYTE, SLOT_E_COMPARE);
      OFS_TIMER_E_HIGH_COMPARE:
        a = mk(KIND_WO, UNITS_BYTE, SLOT_E_HIGH_COMPARE);
      default: a = mk(KIND_NONE, 3'h0, 5'h00);
    endcase
    return a;
  endfunction

  function automatic logic [7:0] rw_reset(input int slot);
    logic [7:0] v;
    v = RST_UNDEFINED;
    if (slot == int'(SLOT_PORT0_DATA))
    begin
      v = RST_PORT0_DATA;
    end
    else if (slot >= int'(SLOT_DIRECTION_0) && slot <= int'(SLOT_DIRECTION_3))
    begin
      v = RST_DIRECTION;
    end
    else if (slot == int'(SLOT_PULLUP_B2) || slot == int'(SLOT_PULLUP_B3))
    begin
      v = RST_PULLUP;
    end
    return v;
  endfunction

  function automatic logic [7:0] ro_reset(input int slot);
    logic [7:0] v;
    v = RST_UNDEFINED;
    if (slot >= int'(SLOT_A_COUNT) && slot <= int'(SLOT_D_COUNT))
    begin
      v = RST_COUNT;
    end
    return v;
  endfunction

  working_reg_file u_working_regs (
    .i_clock(I_CLOCK),
    .i_nrst(I_NRST),
    .i_write(I_GPR_WRITE),
    .i_pair(I_GPR_PAIR),
    .i_sel(I_GPR_SEL),
    .i_wdata(I_GPR_WDATA),
    .o_byte(gpr_byte),
    .o_pair(gpr_pair)
  );

  // anything outside the page belongs to other memory and gets no answer
  assign in_window = (I_ADDR[15:8] == WINDOW_PAGE);
  assign attr = decode(I_ADDR);
  assign width_ok = (I_WIDTH <= WIDTH_WORD) && attr.units[I_WIDTH];
  // an odd word address is refused rather than silently aligned
  assign align_ok = !(I_WIDTH == WIDTH_WORD && I_ADDR[0]);
  assign dir_ok = I_WRITE ? (attr.kind == KIND_RW || attr.kind == KIND_WO)
                          : (attr.kind == KIND_RW || attr.kind == KIND_RO);
  assign access_ok = (attr.kind != KIND_NONE) && width_ok && align_ok
                     && dir_ok;
  assign src_byte = (attr.kind == KIND_RO) ? state_reg.ro[attr.slot]
                                           : state_reg.rw[attr.slot];

  always_comb
  begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.refused = 1'b0;
    // pins are foreign to this clock, so two stages before any reader
    state_next.port6_meta = I_PORT6_PINS;
    state_next.port8_meta = I_PORT8_PINS;
    state_next.ro[SLOT_PORT6] = state_reg.port6_meta;
    state_next.ro[SLOT_PORT8] = state_reg.port8_meta;
    state_next.ro[SLOT_CONVERTER] = I_CONVERTER_RESULT;
    state_next.ro[SLOT_PRODUCT_LOW] = I_PRODUCT_WORD[7:0];
    state_next.ro[SLOT_PRODUCT_HIGH] = I_PRODUCT_WORD[15:8];
    state_next.ro[SLOT_CAPTURE_A] = I_REMOTE_CAPTURE_A;
    state_next.ro[SLOT_CAPTURE_B] = I_REMOTE_CAPTURE_B;
    state_next.ro[SLOT_A_COUNT] = I_TIMER_A_COUNT;
    state_next.ro[SLOT_B_COUNT] = I_TIMER_B_COUNT;
    state_next.ro[SLOT_C_COUNT] = I_TIMER_C_COUNT;
    state_next.ro[SLOT_D_COUNT] = I_TIMER_D_COUNT;
    state_next.gpr_rdata = I_GPR_PAIR ? gpr_pair
                                      : {8'h00, gpr_byte};
    if (I_REQ && in_window)
    begin
      state_next.ack = 1'b1;
      state_next.refused = !access_ok;
      if (I_WRITE && access_ok)
      begin
        // no register accepts a word write, so only bit and byte land here
        if (I_WIDTH == WIDTH_BIT)
        begin
          state_next.rw[attr.slot][I_BIT_POS] = I_WDATA[0];
        end
        else
        begin
          state_next.rw[attr.slot] = I_WDATA[7:0];
        end
      end
      else if (!I_WRITE)
      begin
        if (!access_ok)
        begin
          state_next.rdata = RDATA_REFUSED;
        end
        else if (I_WIDTH == WIDTH_WORD)
        begin
          state_next.rdata = {state_reg.ro[SLOT_PRODUCT_HIGH],
                              state_reg.ro[SLOT_PRODUCT_LOW]};
        end
        else if (I_WIDTH == WIDTH_BIT)
        begin
          state_next.rdata = {15'h0000, src_byte[I_BIT_POS]};
        end
        else
        begin
          state_next.rdata = {8'h00, src_byte};
        end
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_reg <= '0;
      for (int i = 0; i < NUM_RW; i++)
      begin
        state_reg.rw[i] <= rw_reset(i);
      end
      for (int i = 0; i < NUM_RO; i++)
      begin
        state_reg.ro[i] <= ro_reset(i);
      end
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign O_ACK = state_reg.ack;
  assign O_REFUSED = state_reg.refused;
  assign O_RDATA = state_reg.rdata;
  assign O_GPR_RDATA = state_reg.gpr_rdata;
  assign O_PORT0_DATA = state_reg.rw[SLOT_PORT0_DATA];
  assign O_PORT1_DATA = state_reg.rw[SLOT_PORT1_DATA];
  assign O_PORT2_DATA = state_reg.rw[SLOT_PORT2_DATA];
  assign O_PORT3_DATA = state_reg.rw[SLOT_PORT3_DATA];
  assign O_PORT_DIRECTION_0 = state_reg.rw[SLOT_DIRECTION_0];
  assign O_PORT_DIRECTION_1 = state_reg.rw[SLOT_DIRECTION_0 + 5'h01];
  assign O_PORT_DIRECTION_2 = state_reg.rw[SLOT_DIRECTION_0 + 5'h02];
  assign O_PORT_DIRECTION_3 = state_reg.rw[SLOT_DIRECTION_3];
  assign O_PULLUP_OPTION_B2 = state_reg.rw[SLOT_PULLUP_B2];
  assign O_PULLUP_OPTION_B3 = state_reg.rw[SLOT_PULLUP_B3];
  assign O_WATCHDOG_CLOCK_SELECT = state_reg.rw[SLOT_WDOG_CLOCK];
  assign O_WATCH_TIMER_CONTROL = state_reg.rw[SLOT_WATCH_CTRL];
  assign O_WATCHDOG_MODE = state_reg.rw[SLOT_WDOG_MODE];
  assign O_PORT3_FUNCTION = state_reg.rw[SLOT_PORT3_FUNC];
  assign O_REMOTE_TIMER_CONTROL = state_reg.rw[SLOT_REMOTE_CTRL];
  assign O_TIMER_A_COMPARE = state_reg.rw[SLOT_A_COMPARE];
  assign O_TIMER_A_MODE = state_reg.rw[SLOT_A_MODE];
  assign O_TIMER_B_COMPARE = state_reg.rw[SLOT_B_COMPARE];
  assign O_TIMER_B_MODE = state_reg.rw[SLOT_B_MODE];
  assign O_TIMER_C_COMPARE = state_reg.rw[SLOT_C_COMPARE];
  assign O_TIMER_C_MODE = state_reg.rw[SLOT_C_MODE];
  assign O_TIMER_D_COMPARE = state_reg.rw[SLOT_D_COMPARE];
  assign O_TIMER_D_MODE = state_reg.rw[SLOT_D_MODE];
  assign O_TIMER_E_COMPARE = state_reg.rw[SLOT_E_COMPARE];
  assign O_TIMER_E_HIGH_COMPARE = state_reg.rw[SLOT_E_HIGH_COMPARE];

endmodule

// ===== design/sfr_space_pkg.sv
package sfr_space_pkg;

  // page that holds the special function register window
  localparam logic [7:0] WINDOW_PAGE = 8'hFF;

  // access width codes on the request port
  localparam logic [1:0] WIDTH_BIT = 2'h0;
  localparam logic [1:0] WIDTH_BYTE = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;

  // permitted unit masks, bit index equals the width code
  localparam logic [2:0] UNITS_BIT_BYTE = 3'h3;
  localparam logic [2:0] UNITS_BYTE = 3'h2;
  localparam logic [2:0] UNITS_BYTE_WORD = 3'h6;

  // register addresses
  localparam logic [15:0] OFS_PORT0_DATA = 16'hFF00;
  localparam logic [15:0] OFS_PORT1_DATA = 16'hFF01;
  localparam logic [15:0] OFS_PORT2_DATA = 16'hFF02;
  localparam logic [15:0] OFS_PORT3_DATA = 16'hFF03;
  localparam logic [15:0] OFS_PORT6_INPUT = 16'hFF06;
  localparam logic [15:0] OFS_PORT8_INPUT = 16'hFF08;
  localparam logic [15:0] OFS_CONVERTER_RESULT = 16'hFF11;
  localparam logic [15:0] OFS_PRODUCT_LOW = 16'hFF14;
  localparam logic [15:0] OFS_PRODUCT_HIGH = 16'hFF15;
  localparam logic [15:0] OFS_PORT_DIRECTION_0 = 16'hFF20;
  localparam logic [15:0] OFS_PORT_DIRECTION_1 = 16'hFF21;
  localparam logic [15:0] OFS_PORT_DIRECTION_2 = 16'hFF22;
  localparam logic [15:0] OFS_PORT_DIRECTION_3 = 16'hFF23;
  localparam logic [15:0] OFS_PULLUP_OPTION_B2 = 16'hFF32;
  localparam logic [15:0] OFS_PULLUP_OPTION_B3 = 16'hFF33;
  localparam logic [15:0] OFS_WATCHDOG_CLOCK_SELECT = 16'hFF42;
  localparam logic [15:0] OFS_WATCH_TIMER_CONTROL = 16'hFF4A;
  localparam logic [15:0] OFS_WATCHDOG_MODE = 16'hFF4B;
  localparam logic [15:0] OFS_PORT3_FUNCTION = 16'hFF53;
  localparam logic [15:0] OFS_REMOTE_TIMER_CONTROL = 16'hFF54;
  localparam logic [15:0] OFS_REMOTE_CAPTURE_A = 16'hFF55;
  localparam logic [15:0] OFS_REMOTE_CAPTURE_B = 16'hFF56;
  localparam logic [15:0] OFS_TIMER_A_COMPARE = 16'hFF57;
  localparam logic [15:0] OFS_TIMER_A_COUNT = 16'hFF58;
  localparam logic [15:0] OFS_TIMER_A_MODE = 16'hFF59;
  localparam logic [15:0] OFS_TIMER_B_COMPARE = 16'hFF5A;
  localparam logic [15:0] OFS_TIMER_B_COUNT = 16'hFF5B;
  localparam logic [15:0] OFS_TIMER_B_MODE = 16'hFF5C;
  localparam logic [15:0] OFS_TIMER_C_COMPARE = 16'hFF5D;
  localparam logic [15:0] OFS_TIMER_C_COUNT = 16'hFF5E;
  localparam logic [15:0] OFS_TIMER_C_MODE = 16'hFF5F;
  localparam logic [15:0] OFS_TIMER_D_COMPARE = 16'hFF60;
  localparam logic [15:0] OFS_TIMER_D_COUNT = 16'hFF61;
  localparam logic [15:0] OFS_TIMER_D_MODE = 16'hFF62;
  localparam logic [15:0] OFS_TIMER_E_COMPARE = 16'hFF63;
  localparam logic [15:0] OFS_TIMER_E_HIGH_COMPARE = 16'hFF64;

  // storage slots of software-written registers
  localparam int NUM_RW = 25;
  localparam logic [4:0] SLOT_PORT0_DATA = 5'h00;
  localparam logic [4:0] SLOT_PORT1_DATA = 5'h01;
  localparam logic [4:0] SLOT_PORT2_DATA = 5'h02;
  localparam logic [4:0] SLOT_PORT3_DATA = 5'h03;
  localparam logic [4:0] SLOT_DIRECTION_0 = 5'h04;
  localparam logic [4:0] SLOT_DIRECTION_3 = 5'h07;
  localparam logic [4:0] SLOT_PULLUP_B2 = 5'h08;
  localparam logic [4:0] SLOT_PULLUP_B3 = 5'h09;
  localparam logic [4:0] SLOT_WDOG_CLOCK = 5'h0A;
  localparam logic [4:0] SLOT_WATCH_CTRL = 5'h0B;
  localparam logic [4:0] SLOT_WDOG_MODE = 5'h0C;
  localparam logic [4:0] SLOT_PORT3_FUNC = 5'h0D;
  localparam logic [4:0] SLOT_REMOTE_CTRL = 5'h0E;
  localparam logic [4:0] SLOT_A_COMPARE = 5'h0F;
  localparam logic [4:0] SLOT_A_MODE = 5'h10;
  localparam logic [4:0] SLOT_B_COMPARE = 5'h11;
  localparam logic [4:0] SLOT_B_MODE = 5'h12;
  localparam logic [4:0] SLOT_C_COMPARE = 5'h13;
  localparam logic [4:0] SLOT_C_MODE = 5'h14;
  localparam logic [4:0] SLOT_D_COMPARE = 5'h15;
  localparam logic [4:0] SLOT_D_MODE = 5'h16;
  localparam logic [4:0] SLOT_E_COMPARE = 5'h17;
  localparam logic [4:0] SLOT_E_HIGH_COMPARE = 5'h18;

  // storage slots of read-only registers
  localparam int NUM_RO = 11;
  localparam logic [4:0] SLOT_PORT6 = 5'h00;
  localparam logic [4:0] SLOT_PORT8 = 5'h01;
  localparam logic [4:0] SLOT_CONVERTER = 5'h02;
  localparam logic [4:0] SLOT_PRODUCT_LOW = 5'h03;
  localparam logic [4:0] SLOT_PRODUCT_HIGH = 5'h04;
  localparam logic [4:0] SLOT_CAPTURE_A = 5'h05;
  localparam logic [4:0] SLOT_CAPTURE_B = 5'h06;
  localparam logic [4:0] SLOT_A_COUNT = 5'h07;
  localparam logic [4:0] SLOT_B_COUNT = 5'h08;
  localparam logic [4:0] SLOT_C_COUNT = 5'h09;
  localparam logic [4:0] SLOT_D_COUNT = 5'h0A;

  // after-reset values; undefined registers start at RST_UNDEFINED
  localparam logic [7:0] RST_PORT0_DATA = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_UNDEFINED = 8'h00;
  localparam logic [15:0] RDATA_REFUSED = 16'h0000;

endpackage

// ===== design/working_reg_file.sv
`timescale 1ns/100ps
module working_reg_file
  import sfr_space_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_write,
  input wire logic i_pair,
  input wire logic [2:0] i_sel,
  input wire logic [15:0] i_wdata,
  output logic [7:0] o_byte,
  output logic [15:0] o_pair
);

  typedef struct packed {
    logic [7:0][7:0] r;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [2:0] pair_lo;
  logic [2:0] pair_hi;

  // pair n joins bytes 2n (low) and 2n+1 (high)
  assign pair_lo = {i_sel[1:0], 1'b0};
  assign pair_hi = {i_sel[1:0], 1'b1};
  assign o_byte = state_reg.r[i_sel];
  assign o_pair = {state_reg.r[pair_hi], state_reg.r[pair_lo]};

  always_comb
  begin
    state_next = state_reg;
    if (i_write && i_pair)
    begin
      state_next.r[pair_lo] = i_wdata[7:0];
      state_next.r[pair_hi] = i_wdata[15:8];
    end
    else if (i_write)
    begin
      state_next.r[i_sel] = i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule
